// file: src/dimm_pins.sv
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
module dimm_pins (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CK_T,
  input wire logic CK_C,
  input wire logic CS_N,
  input wire dimm_pins_pkg::ca_s CA,
  input wire logic PARITY,
  input wire logic ODT,
  input wire logic [15:0] DQ_I,
  output logic [15:0] DQ_O,
  output logic DQ_OE,
  input wire logic [1:0] DQS_T_I,
  input wire logic [1:0] DQS_C_I,
  output logic [1:0] DQS_T_O,
  output logic [1:0] DQS_C_O,
  output logic DQS_OE,
  input wire logic [1:0] DM_I,
  output logic [1:0] DM_O,
  output logic DM_OE,
  input wire logic ALERT_N_I,
  output logic ALERT_N_O,
  output logic ALERT_N_OE,
  output logic EVENT_N,
  output logic [4:0] TERM_EN,
  output logic [3:0] VREF_MON
);
  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  // device reset: either the system reset or the module reset pin
  logic rst_n;
  assign rst_n = NRST & RESET_N;

  dimm_pins_pkg::pin_s pin_now; // raw pins
  dimm_pins_pkg::pin_s s1; // first stage, read only by s2
  dimm_pins_pkg::pin_s s2; // synchronised pins
  dimm_pins_pkg::pin_s prv; // s2 one cycle ago, for edges

  assign pin_now = '{ck_t: CK_T, ck_c: CK_C, cs_n: CS_N, ca: CA,
                     parity: PARITY, odt: ODT, dq: DQ_I,
                     dqs_t: DQS_T_I, dqs_c: DQS_C_I, dm_n: DM_I,
                     alert_n: ALERT_N_I};

  // two flops before use, third keeps history
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      prv <= '0;
    end
    else
    begin
      s1 <= pin_now;
      s2 <= s1;
      prv <= s2;
    end
  end

  // ----------------------------------------------------------------
  // configuration and mode registers
  // ----------------------------------------------------------------
  logic [1:0] org; // x4, x8 or x16 organisation
  logic conn_test; // connectivity test mode
  logic [7:0] temp; // current temperature, from software
  logic [7:0] tcrit; // critical threshold
  logic [13:0] mr1;
  logic [13:0] mr2;
  logic [13:0] mr4;
  logic [13:0] mr5;
  dimm_pins_pkg::state_e state;

  // derived mode bits
  logic rtt_on;
  logic tdqs_on;
  logic crc_on;
  logic par_on;
  logic dm_on;
  logic wdbi_on;
  logic rdbi_on;
  logic is_x16;
  assign is_x16 = (org == dimm_pins_pkg::ORG_X16);
  assign rtt_on = |mr1[dimm_pins_pkg::MR1_RTT_LSB +: 3];
  assign tdqs_on = (org == dimm_pins_pkg::ORG_X8) &
                   mr1[dimm_pins_pkg::MR1_TDQS_BIT];
  assign crc_on = mr2[dimm_pins_pkg::MR2_CRC_BIT];
  assign par_on = |mr5[dimm_pins_pkg::MR5_PAR_LSB +: 3];
  assign dm_on = mr5[dimm_pins_pkg::MR5_DM_BIT] & ~tdqs_on &
                 (org != dimm_pins_pkg::ORG_X4);
  assign wdbi_on = mr5[dimm_pins_pkg::MR5_WDBI_BIT] & ~dm_on &
                   (org != dimm_pins_pkg::ORG_X4);
  assign rdbi_on = mr5[dimm_pins_pkg::MR5_RDBI_BIT] & ~tdqs_on &
                   (org != dimm_pins_pkg::ORG_X4);

  // ----------------------------------------------------------------
  // command sampling
  // ----------------------------------------------------------------
  logic ck_rise; // differential crossing, t high c low
  logic cmd_valid;
  logic par_err;
  logic par_busy;
  logic cmd_ok;
  logic [2:0] cmd3;
  assign ck_rise = s2.ck_t & ~s2.ck_c & ~(prv.ck_t & ~prv.ck_c);
  assign cmd_valid = ck_rise & ~s2.cs_n;
  assign par_err = cmd_valid & par_on & (^{s2.ca, s2.parity});
  // commands during parity recovery are dropped
  assign cmd_ok = cmd_valid & ~par_err & ~par_busy;
  assign cmd3 = {s2.ca.ras_n, s2.ca.cas_n, s2.ca.we_n};

  logic cmd_mrs;
  logic cmd_wr;
  logic cmd_rd;
  assign cmd_mrs = cmd_ok & s2.ca.act_n &
                   (cmd3 == dimm_pins_pkg::CMD_MRS);
  assign cmd_wr = cmd_ok & s2.ca.act_n & (cmd3 == dimm_pins_pkg::CMD_WR);
  assign cmd_rd = cmd_ok & s2.ca.act_n & (cmd3 == dimm_pins_pkg::CMD_RD);

  // mode register set, selected by bg0 and ba
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mr1 <= '0;
      mr2 <= '0;
      mr4 <= '0;
      mr5 <= '0;
    end
    else if (cmd_mrs && state == dimm_pins_pkg::ST_IDLE)
    begin
      if ({s2.ca.bg[0], s2.ca.ba} == dimm_pins_pkg::MR_SEL1)
        mr1 <= s2.ca.addr;
      else if ({s2.ca.bg[0], s2.ca.ba} == dimm_pins_pkg::MR_SEL2)
        mr2 <= s2.ca.addr;
      else if ({s2.ca.bg[0], s2.ca.ba} == dimm_pins_pkg::MR_SEL4)
        mr4 <= s2.ca.addr;
      else if ({s2.ca.bg[0], s2.ca.ba} == dimm_pins_pkg::MR_SEL5)
        mr5 <= s2.ca.addr;
    end
  end

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  logic [1:0] dqs_edge; // per strobe pair, either edge
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_dqs
      // count only a true differential edge
      assign dqs_edge[g] = (s2.dqs_t[g] ^ prv.dqs_t[g]) &
                           (s2.dqs_t[g] ^ s2.dqs_c[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // burst sequencer
  // ----------------------------------------------------------------
  logic [2:0] col; // burst base column
  logic [2:0] beat; // beat within the burst
  logic [2:0] tmr; // clock cycles within a read beat
  logic last_beat;
  logic rd_crc_beat; // read beat past the data
  logic tick; // start of a read beat
  assign last_beat = (beat == 3'(dimm_pins_pkg::BURST_LEN - 1));
  assign tick = (tmr == 3'h0);

  // state, beat and timing
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= dimm_pins_pkg::ST_IDLE;
      col <= 3'h0;
      beat <= 3'h0;
      tmr <= 3'h0;
      rd_crc_beat <= 1'b0;
    end
    else
    begin
      case (state)
        dimm_pins_pkg::ST_IDLE:
        begin
          beat <= 3'h0;
          tmr <= 3'h0;
          rd_crc_beat <= 1'b0;
          col <= s2.ca.addr[5:3];
          if (cmd_wr)
            state <= dimm_pins_pkg::ST_WRITE;
          else if (cmd_rd)
            state <= dimm_pins_pkg::ST_READ;
        end
        dimm_pins_pkg::ST_WRITE:
        begin
          if (dqs_edge[0])
          begin
            beat <= beat + 3'h1;
            if (last_beat)
              state <= crc_on ? dimm_pins_pkg::ST_WCRC
                              : dimm_pins_pkg::ST_IDLE;
          end
        end
        dimm_pins_pkg::ST_WCRC:
        begin
          if (dqs_edge[0])
            state <= dimm_pins_pkg::ST_IDLE;
        end
        dimm_pins_pkg::ST_READ:
        begin
          // half a link period per beat
          if (tmr == 3'(dimm_pins_pkg::BEAT_CYC - 1))
          begin
            tmr <= 3'h0;
            beat <= beat + 3'h1;
            if (rd_crc_beat || (last_beat && !crc_on))
              state <= dimm_pins_pkg::ST_IDLE;
            else if (last_beat)
              rd_crc_beat <= 1'b1;
          end
          else
            tmr <= tmr + 3'h1;
        end
        default:
          state <= dimm_pins_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // byte lanes: storage, mask, inversion
  // ----------------------------------------------------------------
  logic [5:0] idx;
  assign idx = {col, beat};
  logic [15:0] rd_raw; // stored data at the read index
  logic [15:0] rd_drv; // data as driven, after inversion
  logic [1:0] rd_inv; // lane driven inverted
  logic [1:0] lane_live; // lane exists in this organisation
  assign lane_live = {is_x16, 1'b1};

  generate
    for (g = 0; g < 2; g++)
    begin : g_lane
      logic [7:0] mem [0:63]; // one byte per beat per burst slot
      logic [7:0] wbyte;
      logic [3:0] ones;
      logic keep;
      assign wbyte = s2.dq[8 * g +: 8];
      assign keep = ~(dm_on & ~s2.dm_n[g]);
      // each lane has its own strobe on x16
      always_ff @(posedge CLK_SYS)
      begin
        if (state == dimm_pins_pkg::ST_WRITE && dqs_edge[is_x16 ? g : 0]
            && keep && lane_live[g])
          mem[idx] <= (wdbi_on & ~s2.dm_n[g]) ? ~wbyte : wbyte;
      end
      assign rd_raw[8 * g +: 8] = mem[idx];
      assign ones = 4'($countones(mem[idx]));
      // invert when more than half the bits are zero
      assign rd_inv[g] = rdbi_on & (ones < 4'h4);
      assign rd_drv[8 * g +: 8] = rd_inv[g] ? ~rd_raw[8 * g +: 8]
                                            : rd_raw[8 * g +: 8];
    end
  endgenerate

  // ----------------------------------------------------------------
  // crc accumulation and check
  // ----------------------------------------------------------------
  // xor checksum of the beats as they cross the pins
  logic [15:0] crc_acc;
  logic crc_err;
  assign crc_err = (state == dimm_pins_pkg::ST_WCRC) & dqs_edge[0] &
                   (s2.dq != crc_acc);

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      crc_acc <= 16'h0000;
    else if (state == dimm_pins_pkg::ST_IDLE)
      crc_acc <= 16'h0000;
    else if (state == dimm_pins_pkg::ST_WRITE && dqs_edge[0])
      crc_acc <= crc_acc ^ s2.dq;
    else if (state == dimm_pins_pkg::ST_READ && tick && !rd_crc_beat)
      crc_acc <= crc_acc ^ rd_drv;
  end

  // ----------------------------------------------------------------
  // read drivers
  // ----------------------------------------------------------------
  // data and strobe change on the same edge
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      DQ_O <= 16'h0000;
      DQ_OE <= 1'b0;
      DQS_T_O <= 2'h0;
      DQS_C_O <= 2'h3;
      DQS_OE <= 1'b0;
      DM_O <= 2'h3;
      DM_OE <= 1'b0;
    end
    else if (state == dimm_pins_pkg::ST_READ && tick)
    begin
      DQ_O <= rd_crc_beat ? crc_acc : rd_drv;
      DQS_T_O <= {2{~beat[0]}};
      DQS_C_O <= {2{beat[0]}};
      DQ_OE <= 1'b1;
      DQS_OE <= 1'b1;
      DM_O <= rd_crc_beat ? 2'h3 : ~rd_inv;
      DM_OE <= rdbi_on;
    end
    else if (state != dimm_pins_pkg::ST_READ)
    begin
      DQ_OE <= 1'b0;
      DQS_OE <= 1'b0;
      DM_OE <= 1'b0;
      DQS_T_O <= 2'h0;
      DQS_C_O <= 2'h3;
    end
  end

  // ----------------------------------------------------------------
  // alert
  // ----------------------------------------------------------------
  logic [5:0] alert_cnt; // cycles of alert left
  logic alert_par; // current alert is a parity recovery
  logic [7:0] crc_cnt;
  logic [7:0] par_cnt;
  assign par_busy = alert_par;

  // a new crc error, or a parity error outside parity recovery, restarts the alert; set beats expiry
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alert_cnt <= 6'h00;
      alert_par <= 1'b0;
      crc_cnt <= 8'h00;
      par_cnt <= 8'h00;
    end
    else if (par_err && !par_busy)
    begin
      alert_cnt <= 6'(dimm_pins_pkg::PAR_REC_CYC);
      alert_par <= 1'b1;
      par_cnt <= par_cnt + 8'h01;
    end
    else if (crc_err)
    begin
      alert_cnt <= 6'(dimm_pins_pkg::ALERT_CRC_CYC);
      crc_cnt <= crc_cnt + 8'h01;
    end
    else if (alert_cnt != 6'h00)
    begin
      alert_cnt <= alert_cnt - 6'h01;
      if (alert_cnt == 6'h01)
        alert_par <= 1'b0;
    end
  end

  // open-drain alert, released in test mode
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ALERT_N_O <= 1'b0;
      ALERT_N_OE <= 1'b0;
    end
    else
    begin
      ALERT_N_O <= 1'b0;
      ALERT_N_OE <= (alert_cnt != 6'h00) & ~conn_test;
    end
  end

  // ----------------------------------------------------------------
  // termination, vref monitor, event
  // ----------------------------------------------------------------
  logic odt_lat; // odt sampled at the clock crossing

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      odt_lat <= 1'b0;
    else if (ck_rise)
      odt_lat <= s2.odt & rtt_on;
  end

  // bits: lane0, lane1, mask0, mask1, tdqs_c
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      TERM_EN <= 5'h00;
      VREF_MON <= 4'h0;
      EVENT_N <= 1'b1;
    end
    else
    begin
      TERM_EN[0] <= odt_lat;
      TERM_EN[2] <= odt_lat;
      TERM_EN[1] <= odt_lat & is_x16;
      TERM_EN[3] <= odt_lat & is_x16;
      TERM_EN[4] <= odt_lat & tdqs_on;
      // vref seen on dq0 to dq3
      VREF_MON <= {4{mr4[dimm_pins_pkg::MR4_VREF_BIT]}};
      EVENT_N <= ~(temp > tcrit);
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic wb_req;
  logic wb_wr;
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];

  // one wait state, ack for any address
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= wb_req;
  end

  // writable registers, low byte lane only
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      org <= dimm_pins_pkg::ORG_RST;
      conn_test <= 1'b0;
      temp <= dimm_pins_pkg::TEMP_RST;
      tcrit <= dimm_pins_pkg::TCRIT_RST;
    end
    else if (wb_wr)
    begin
      if (WB_ADR_I == dimm_pins_pkg::REG_CFG)
      begin
        org <= WB_DAT_I[dimm_pins_pkg::CFG_ORG_LSB +: 2];
        conn_test <= WB_DAT_I[dimm_pins_pkg::CFG_CONN_BIT];
      end
      else if (WB_ADR_I == dimm_pins_pkg::REG_TEMP)
        temp <= WB_DAT_I[7:0];
      else if (WB_ADR_I == dimm_pins_pkg::REG_TCRIT)
        tcrit <= WB_DAT_I[7:0];
    end
  end

  // read data, unmapped reads as zero
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      WB_DAT_O <= 32'h00000000;
    else if (wb_req && !WB_WE_I)
    begin
      if (WB_ADR_I == dimm_pins_pkg::REG_CFG)
        WB_DAT_O <= {29'h0, conn_test, org};
      else if (WB_ADR_I == dimm_pins_pkg::REG_TEMP)
        WB_DAT_O <= {24'h0, temp};
      else if (WB_ADR_I == dimm_pins_pkg::REG_TCRIT)
        WB_DAT_O <= {24'h0, tcrit};
      else if (WB_ADR_I == dimm_pins_pkg::REG_STAT)
        WB_DAT_O <= {13'h0, ~EVENT_N, s2.alert_n, alert_cnt != 6'h00,
                     par_cnt, crc_cnt};
      else if (WB_ADR_I == dimm_pins_pkg::REG_MODE)
        WB_DAT_O <= {24'h0, rtt_on, tdqs_on, crc_on, par_on,
                     mr4[dimm_pins_pkg::MR4_VREF_BIT], dm_on, wdbi_on,
                     rdbi_on};
      else
        WB_DAT_O <= 32'h00000000;
    end
  end
endmodule : dimm_pins

// file: src/dimm_pins_pkg.sv
package dimm_pins_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int BEAT_NS = 200;
  localparam int BEAT_CYC = BEAT_NS / CLK_NS;
  localparam int ALERT_CRC_NS = 600;
  localparam int ALERT_CRC_CYC = (ALERT_CRC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAR_REC_NS = 2000;
  localparam int PAR_REC_CYC = (PAR_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int BURST_LEN = 8;
  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_TEMP = 8'h04;
  localparam logic [7:0] REG_TCRIT = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_MODE = 8'h10;
  localparam int CFG_ORG_LSB = 0;
  localparam int CFG_CONN_BIT = 2;
  localparam logic [1:0] ORG_X4 = 2'h0;
  localparam logic [1:0] ORG_X8 = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;
  localparam logic [1:0] ORG_RST = ORG_X8;
  localparam logic [7:0] TEMP_RST = 8'h19;
  localparam logic [7:0] TCRIT_RST = 8'h5F;
  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int MR1_RTT_LSB = 8;
  localparam int MR1_TDQS_BIT = 11;
  localparam int MR2_CRC_BIT = 12;
  localparam int MR4_VREF_BIT = 4;
  localparam int MR5_PAR_LSB = 0;
  localparam int MR5_DM_BIT = 10;
  localparam int MR5_WDBI_BIT = 11;
  localparam int MR5_RDBI_BIT = 12;
  localparam logic [2:0] MR_SEL1 = 3'h1;
  localparam logic [2:0] MR_SEL2 = 3'h2;
  localparam logic [2:0] MR_SEL4 = 3'h4;
  localparam logic [2:0] MR_SEL5 = 3'h5;
  // command codes on {ras_n, cas_n, we_n} with act_n high
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [13:0] addr;
  } ca_s;
  typedef struct packed {
    logic ck_t;
    logic ck_c;
    logic cs_n;
    ca_s ca;
    logic parity;
    logic odt;
    logic [15:0] dq;
    logic [1:0] dqs_t;
    logic [1:0] dqs_c;
    logic [1:0] dm_n;
    logic alert_n;
  } pin_s;
  typedef enum {ST_IDLE, ST_WRITE, ST_WCRC, ST_READ} state_e;
endpackage : dimm_pins_pkg

// file: test/dimm_pins_asserts.sv
`timescale 1ns/1ns
// ----------------------------------------------------------
// pin checks, top ports only
// ----------------------------------------------------------
module dimm_pins_asserts (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic RESET_N,
  input wire logic ODT,
  input wire logic DQ_OE,
  input wire logic DQS_OE,
  input wire logic [1:0] DQS_T_O,
  input wire logic [1:0] DQS_C_O,
  input wire logic ALERT_N_O,
  input wire logic ALERT_N_OE,
  input wire logic EVENT_N,
  input wire logic [4:0] TERM_EN,
  input wire logic [3:0] VREF_MON
);
  // either reset aborts whatever is in flight, except reset_hold_a, which only NRST disables
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST || !RESET_N);
  reset_hold_a: assert property (disable iff (!NRST)
    !RESET_N |-> !DQ_OE && !ALERT_N_OE && EVENT_N && TERM_EN == 5'h0)
    else $error("pins active in reset");
  alert_drive_a: assert property (ALERT_N_OE |-> !ALERT_N_O)
    else $error("alert enabled but not low");
  alert_min_a: assert property ($rose(ALERT_N_OE) |-> ALERT_N_OE [*8])
    else $error("alert pulse too short");
  vref_all_a: assert property (VREF_MON == 4'h0 || VREF_MON == 4'hF)
    else $error("partial vref monitor");
  term_off_a: assert property (!ODT [*6] |-> TERM_EN == 5'h0)
    else $error("termination without odt");
  strobe_pair_a: assert property (DQS_T_O == ~DQS_C_O)
    else $error("strobe pair not complementary");
  read_oe_a: assert property (DQ_OE == DQS_OE)
    else $error("strobe and data enables differ");
  strobe_edge_a: assert property ($rose(DQS_OE) |->
    DQS_T_O[0] ##4 !DQS_T_O[0])
    else $error("strobe not toggling with beats");
endmodule : dimm_pins_asserts
bind dimm_pins dimm_pins_asserts chk_u (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .RESET_N(RESET_N), .ODT(ODT), .DQ_OE(DQ_OE), .DQS_OE(DQS_OE),
  .DQS_T_O(DQS_T_O), .DQS_C_O(DQS_C_O), .ALERT_N_O(ALERT_N_O),
  .ALERT_N_OE(ALERT_N_OE), .EVENT_N(EVENT_N), .TERM_EN(TERM_EN),
  .VREF_MON(VREF_MON));

// file: test/dimm_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------
// host controller side of the link
// ----------------------------------------------------------
module dimm_host_model (
  input wire logic clk,
  output logic ck_t,
  output logic ck_c,
  output logic cs_n,
  output dimm_pins_pkg::ca_s ca,
  output logic parity,
  output logic [15:0] dq,
  output logic [1:0] dqs_t,
  output logic [1:0] dqs_c,
  output logic [1:0] dm
);
  assign dqs_c = ~dqs_t;
  // link clock parked low between frames
  initial
  begin
    {ck_t, ck_c, cs_n, parity, dqs_t, dm} = 8'h6C;
    ca = '0;
    dq = '0;
  end
  task automatic cmd(input logic sel_n, input dimm_pins_pkg::ca_s c,
    input logic bad);
    @(posedge clk);
    cs_n <= sel_n;
    ca <= c;
    parity <= ^c ^ bad;
    repeat (4) @(posedge clk);
    {ck_t, ck_c} <= 2'h2;
    repeat (4) @(posedge clk);
    {ck_t, ck_c} <= 2'h1;
    cs_n <= 1'b1;
    // released pins show the inverse, not a stale value
    ca <= ~c;
    parity <= ~parity;
  endtask : cmd
  task automatic burst(input logic [15:0] d [9], input logic [1:0] m [9],
    input int n);
    for (int b = 0; b < n; b++)
    begin
      @(posedge clk);
      dq <= d[b];
      dm <= m[b];
      repeat (4) @(posedge clk);
      dqs_t <= ~dqs_t;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    dq <= ~dq;
    dm <= ~dm;
  endtask : burst
endmodule : dimm_host_model

// file: test/dimm_pins_bench.sv
`timescale 1ns/1ns
module dimm_pins_bench;
  logic clk, nrst, reset_n, cyc, stb, we, odt, ack, dq_oe, dqs_oe, dm_oe;
  logic alert_o, alert_oe, event_n, ck_t, ck_c, cs_n, parity;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q, seed;
  logic [15:0] dq_o, h_dq, mem [64];
  logic [1:0] dqs_t_o, dqs_c_o, dm_o, h_dqs_t, h_dqs_c, h_dm;
  logic [4:0] term_en;
  logic [3:0] vref_mon;
  logic dm_on, wdbi, rdbi, crc_on;
  dimm_pins_pkg::ca_s ca;
  int n_mismatch, samples_checked, cycles;
  wire [21:0] rd_pins = {dm_oe, dq_oe, dm_o, dqs_t_o, dq_o};
  wire [11:0] rst_pins = {dq_oe, alert_oe, event_n, term_en, vref_mon};
  dimm_pins dut_u (.CLK_SYS(clk), .NRST(nrst), .RESET_N(reset_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CK_T(ck_t), .CK_C(ck_c), .CS_N(cs_n), .CA(ca), .PARITY(parity),
    .ODT(odt), .DQ_I(dq_oe ? dq_o : h_dq), .DQ_O(dq_o), .DQ_OE(dq_oe),
    .DQS_T_I(dqs_oe ? dqs_t_o : h_dqs_t), .DQS_T_O(dqs_t_o),
    .DQS_C_I(dqs_oe ? dqs_c_o : h_dqs_c), .DQS_C_O(dqs_c_o),
    .DQS_OE(dqs_oe), .DM_I(dm_oe ? dm_o : h_dm), .DM_O(dm_o), .DM_OE(dm_oe),
    .ALERT_N_I(alert_oe ? alert_o : 1'b1), .ALERT_N_O(alert_o),
    .ALERT_N_OE(alert_oe), .EVENT_N(event_n), .TERM_EN(term_en),
    .VREF_MON(vref_mon));
  dimm_host_model host_u (.clk(clk), .ck_t(ck_t), .ck_c(ck_c), .cs_n(cs_n),
    .ca(ca), .parity(parity), .dq(h_dq), .dqs_t(h_dqs_t),
    .dqs_c(h_dqs_c), .dm(h_dm));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic dimm_pins_pkg::ca_s mk(input logic [2:0] op,
    input logic [2:0] mr, input logic [13:0] a);
    return {1'b1, op, 1'b0, mr, a};
  endfunction : mk
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checked %0d, mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    q = rdat;
    chk(ack, 1'b1);
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic mrs(input logic [2:0] mr, input logic [13:0] v);
    host_u.cmd(1'b0, mk(dimm_pins_pkg::CMD_MRS, mr, v), 1'b0);
    repeat (4) @(posedge clk);
    if (mr == dimm_pins_pkg::MR_SEL5)
      {rdbi, wdbi, dm_on} = v[12:10];
    if (mr == dimm_pins_pkg::MR_SEL2)
      crc_on = v[12];
  endtask : mrs
  // ctl 1: chip select high, ctl 2: activate; both must be ignored
  task automatic wburst(input logic [2:0] col, input logic [1:0] ctl,
    input logic bad);
    logic [15:0] d [9];
    logic [1:0] m [9];
    dimm_pins_pkg::ca_s c;
    d[8] = '0;
    m[8] = 2'h3;
    for (int b = 0; b < 8; b++)
    begin
      seed = lfsr(seed);
      {m[b], d[b]} = seed[17:0];
      d[8] = d[8] ^ d[b];
      for (int l = 0; l < 2; l++)
        if (ctl == 2'h0 && !(dm_on && !m[b][l]))
          mem[{col, b[2:0]}][l*8 +: 8] = d[b][l*8 +: 8] ^ {8{wdbi & !m[b][l]}};
    end
    d[8][0] = d[8][0] ^ bad;
    c = mk(dimm_pins_pkg::CMD_WR, 3'h0, {8'h0, col, 3'h0});
    c.act_n = ~ctl[1];
    host_u.cmd(ctl[0], c, 1'b0);
    host_u.burst(d, m, crc_on ? 9 : 8);
  endtask : wburst
  task automatic rburst(input logic [2:0] col);
    logic [15:0] e, x;
    logic [1:0] inv;
    int k;
    x = '0;
    k = 0;
    fork
      host_u.cmd(1'b0, mk(dimm_pins_pkg::CMD_RD, 3'h0, {8'h0, col, 3'h0}), 0);
      begin
        while (dq_oe !== 1'b1 && k < 60)
        begin
          @(negedge clk);
          k++;
        end
        for (int b = 0; b < 9; b++)
        begin
          e = b < 8 ? mem[{col, b[2:0]}] : x;
          for (int l = 0; l < 2; l++)
            inv[l] = rdbi && b < 8 && $countones(e[l*8 +: 8]) < 4;
          e = e ^ {{8{inv[1]}}, {8{inv[0]}}};
          x = x ^ e;
          if (b < 8 || crc_on)
            chk(rd_pins, {rdbi, 1'b1, ~inv, {2{~b[0]}}, e});
          repeat (4) @(negedge clk);
        end
      end
    join
    repeat (4) @(posedge clk);
    chk(dq_oe, 1'b0);
  endtask : rburst
  task automatic alert_len(input int want);
    int k, n;
    k = 0;
    n = 0;
    while (alert_oe !== 1'b1 && k < 300)
    begin
      @(negedge clk);
      k++;
    end
    while (alert_oe === 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, want);
  endtask : alert_len
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    {nrst, reset_n, cyc, stb, we, odt, adr, wdat} = '0;
    reset_n = 1'b1;
    {dm_on, wdbi, rdbi, crc_on} = 4'h0;
    seed = 32'h7E8E;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    chk(rst_pins, 12'h200);
    wb(1'b0, dimm_pins_pkg::REG_CFG, 0);
    chk(q, dimm_pins_pkg::ORG_RST);
    wb(1'b1, dimm_pins_pkg::REG_CFG, dimm_pins_pkg::ORG_X16);
    wb(1'b0, 8'h40, 0);
    chk(q, 0);
    $display("test registers done");
    for (int t = 0; t < 3; t++)
    begin
      mrs(dimm_pins_pkg::MR_SEL5, t == 1 ? 14'h0400 : t == 2 ? 14'h1800 : 0);
      wburst(3'h0, 2'h0, 1'b0);
      wburst(3'h1, 2'h0, 1'b0);
      wburst(3'h0, 2'h1, 1'b0);
      wburst(3'h1, 2'h2, 1'b0);
      rburst(3'h0);
      rburst(3'h1);
      $display("test data mode %0d done", t);
    end
    mrs(dimm_pins_pkg::MR_SEL5, 0);
    mrs(dimm_pins_pkg::MR_SEL2, 14'h1000);
    for (int bad = 0; bad < 2; bad++)
      fork
        wburst(3'h7, 2'h0, bad[0]);
        alert_len(bad ? 12 : 0);
      join
    rburst(3'h1);
    mrs(dimm_pins_pkg::MR_SEL5, 14'h0001);
    fork
      host_u.cmd(1'b0, mk(dimm_pins_pkg::CMD_RD, 3'h0, 0), 1'b1);
      alert_len(40);
    join
    rburst(3'h0);
    wb(1'b0, dimm_pins_pkg::REG_STAT, 0);
    chk(q[15:0], 16'h0101);
    $display("test crc and parity done");
    odt <= 1'b1;
    repeat (8) @(posedge clk);
    chk(term_en, 0);
    mrs(dimm_pins_pkg::MR_SEL1, 14'h0100);
    // odt is latched at a clock crossing, so a later command samples it
    mrs(dimm_pins_pkg::MR_SEL4, 14'h0010);
    chk(term_en, 5'h0F);
    chk(vref_mon, 4'hF);
    for (int v = 8'h5F; v < 8'h61; v++)
    begin
      wb(1'b1, dimm_pins_pkg::REG_TEMP, v);
      repeat (4) @(posedge clk);
      chk(event_n, v == 8'h5F);
    end
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(rst_pins, 12'h200);
    reset_n <= 1'b1;
    wb(1'b0, dimm_pins_pkg::REG_MODE, 0);
    chk(q, 0);
    $display("test pins and reset done");
    complete_run();
  end
  // hang guard, far beyond the roughly two thousand cycles needed
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
endmodule : dimm_pins_bench
